/* hdl/hbb_host_bridge.sv */
`timescale 1ns/1ns
`include "hbb_params.svh"
// ----------------------------------------------------------------
// Overview of operation
// R1 - Processor reset follows io-bus reset, and suspend in mobile mode.
// R2 - Request strobe appears only in the first clock of a request phase.
// R3 - Command lines valid in both request clocks: snoop type, then rest.
// R4 - Bridge raises priority request to take the address bus.
// R5 - Symmetric request zero held in reset, dropped two clocks after it.
// R6 - Block-next-request stops further requests, limiting pipeline depth.
// R7 - Data bus owner holds data-bus-busy for transfers longer than one cycle.
// R8 - Defer output gives deferred responses and also signals retry.
// R9 - Data-valid strobe asserted in every clock that carries data.
// R10 - Modified holder raises hit-modified and supplies the line.
// R11 - Locked cycles atomic; no snoopable io or graphics access meanwhile.
// R12 - Target ready shows the target can enter the data phase.
// R13 - Response codes: 000 idle, 001 retry, 010 defer, 101, 110, 111.
// R14 - Codes 011 and 100 are never driven.
// R15 - Host data travels inverted on the processor bus.
// R16 - Address bits 31 to 3 are inputs during processor cycles.
// R17 - No addressing above 4 GB; address bits 35 to 32 ignored.
// R18 - No parity, ECC, bus-init recovery or bus-error signalling.
// R19 - Bus outputs other than processor reset and symmetric request zero released within two clocks of reset.
// R20 - Bus signals active low, driven and sampled on rising clock.
// ----------------------------------------------------------------
module hbb_host_bridge
  import hbb_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic ioBusResetInN,
  input wire logic suspendStatusInN,
  input wire logic mobileMode,
  output logic processorResetOutN,
  output logic symmetricRequestZeroN,
  output logic symmetricRequestZeroOeN,
  output logic priorityAgentRequestN,
  output logic priorityAgentRequestOeN,
  input wire logic requestStrobeInN,
  input wire logic [`HBB_CMD_W-1:0] requestCommandInN,
  input wire logic [`HBB_ADDR_MSB:`HBB_ADDR_LSB] hostAddrInN,
  input wire logic hostLockInN,
  input wire logic snoopHitModifiedInN,
  output logic blockNextRequestN,
  output logic blockNextRequestOeN,
  output logic dataBusBusyN,
  output logic dataBusBusyOeN,
  input wire logic dataValidStrobeInN,
  output logic dataValidStrobeN,
  output logic dataValidStrobeOeN,
  output logic hostTargetReadyN,
  output logic hostTargetReadyOeN,
  output logic deferN,
  output logic deferOeN,
  output logic [`HBB_RSP_W-1:0] responseStatusN,
  output logic responseStatusOeN,
  input wire logic [`HBB_DATA_W-1:0] hostDataBusInN,
  output logic [`HBB_DATA_W-1:0] hostDataBusN,
  output logic hostDataBusOeN,
  input wire logic busHoldReq,
  output logic cpuReqValid,
  output logic [`HBB_ADDR_MSB:`HBB_ADDR_LSB] cpuReqAddr,
  output logic [`HBB_CMD_W-1:0] cpuReqCmdFirst,
  output logic [`HBB_CMD_W-1:0] cpuReqCmdSecond,
  output logic cpuReqSnoopHit,
  input wire logic ansValid,
  input wire hbb_ans_type ansKind,
  input wire logic [`HBB_DATA_W-1:0] ansData,
  output logic wrDataValid,
  output logic [`HBB_DATA_W-1:0] wrData,
  output logic atomicHold
);

  // ----------------------------------------------------------------
  // reset generation
  // ----------------------------------------------------------------
  hbb_rst_if rstIf();

  hbb_reset_gen u_reset_gen (
    .clock(clock),
    .nrst(nrst),
    .ioBusResetInN(ioBusResetInN),
    .suspendStatusInN(suspendStatusInN),
    .mobileMode(mobileMode),
    .rst(rstIf.gen)
  );

  logic processor_reset_out;
  assign processor_reset_out = rstIf.cpuResetAct;
  // R1 processor reset pin driven low while reset is active
  assign processorResetOutN = ~processor_reset_out;
  // R5 open-drain style: pull low while asserted, else release
  assign symmetricRequestZeroN = 1'b0;
  assign symmetricRequestZeroOeN = ~rstIf.breq0Act;

  // ----------------------------------------------------------------
  // request capture and sequencing
  // ----------------------------------------------------------------
  hbb_state_type st_q, st_d;
  logic [`HBB_ADDR_MSB:`HBB_ADDR_LSB] addr_q, addr_d;
  logic [`HBB_CMD_W-1:0] cmdA_q, cmdA_d, cmdB_q, cmdB_d;
  logic snoop_hit_modified_q, snoop_hit_modified_d, lock_q, lock_d;
  logic strobeSeen;

  // R20 active-low pins sampled on the rising edge, no synchroniser
  assign strobeSeen = ~requestStrobeInN & (st_q == ST_IDLE) & ~processor_reset_out;

  hbb_rsp_type rsp_q, rsp_d;
  logic bnr_q, bnr_d, priority_agent_request_q, priority_agent_request_d, data_valid_strobe_q, data_valid_strobe_d;
  logic host_target_ready_q, host_target_ready_d, defer_q, defer_d, wrV_q, wrV_d;
  logic [`HBB_DATA_W-1:0] rdData_q, rdData_d, wr_q, wr_d;

  // next-state and next-output computation
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    cmdA_d = cmdA_q;
    cmdB_d = cmdB_q;
    snoop_hit_modified_d = snoop_hit_modified_q;
    rsp_d = RSP_IDLE;
    data_valid_strobe_d = 1'b0;
    host_target_ready_d = 1'b0;
    defer_d = 1'b0;
    wrV_d = 1'b0;
    rdData_d = rdData_q;
    wr_d = wr_q;
    unique case (st_q)
      ST_IDLE: begin
        // R2 the strobe marks the first request clock only
        if (strobeSeen) begin
          // R16 address is an input; R17 bits above 31 never read
          addr_d = ~hostAddrInN;
          // R3 first clock: type detail enough to start the snoop
          cmdA_d = ~requestCommandInN;
          st_d = ST_REQ2;
        end
      end
      ST_REQ2: begin
        // R3 second clock: remaining transaction type
        cmdB_d = ~requestCommandInN;
        // R10 a modified hit means the processor supplies the line
        snoop_hit_modified_d = ~snoopHitModifiedInN;
        st_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (ansValid) begin
          if (snoop_hit_modified_q || ansKind == ANS_WRITE) begin
            // R12 target ready before taking data from the processor
            host_target_ready_d = 1'b1;
            st_d = ST_TRDY;
          end else begin
            st_d = ST_RESP;
            unique case (ansKind)
              ANS_RETRY: begin
                // R8 retry signalled through the defer output too
                defer_d = 1'b1;
                rsp_d = RSP_RETRY;
              end
              ANS_DEFER: begin
                // R8 deferred reply under the defer policy
                defer_d = 1'b1;
                rsp_d = RSP_DEFERRED;
              end
              ANS_NORMAL: begin
                // R9 data valid only in the clock that carries it
                data_valid_strobe_d = 1'b1;
                rsp_d = RSP_NORMAL;
                rdData_d = ansData;
              end
              default: begin
                rsp_d = RSP_NO_DATA;
              end
            endcase
          end
        end
      end
      ST_TRDY: begin
        st_d = ST_DATAIN;
      end
      ST_DATAIN: begin
        if (!dataValidStrobeInN) begin
          // R15 bus data is inverted, so flip it on the way in
          wr_d = ~hostDataBusInN;
          wrV_d = 1'b1;
          // R13 implicit writeback when a modified copy answered
          rsp_d = snoop_hit_modified_q ? RSP_WRITEBACK : RSP_NO_DATA;
          st_d = ST_RESP;
        end
      end
      ST_RESP: begin
        st_d = ST_IDLE;
      end
    endcase
    // R19 reset from the processor side drops state, response, data strobe, target ready and defer
    if (processor_reset_out) begin
      st_d = ST_IDLE;
      rsp_d = RSP_IDLE;
      data_valid_strobe_d = 1'b0;
      host_target_ready_d = 1'b0;
      defer_d = 1'b0;
    end
    // R6 one transaction in flight: block while the sequencer is busy
    bnr_d = (st_d != ST_IDLE) & ~processor_reset_out;
    // R4 priority request while the local paths want the address bus
    priority_agent_request_d = busHoldReq & ~processor_reset_out;
    // R11 lock starts with a strobed request and ends on negation
    lock_d = (lock_q | (strobeSeen & ~hostLockInN)) & ~hostLockInN
      & ~processor_reset_out;
  end

  // register the sequencer and its outputs
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      addr_q <= '0;
      cmdA_q <= '0;
      cmdB_q <= '0;
      snoop_hit_modified_q <= 1'b0;
      lock_q <= 1'b0;
      rsp_q <= RSP_IDLE;
      bnr_q <= 1'b0;
      priority_agent_request_q <= 1'b0;
      data_valid_strobe_q <= 1'b0;
      host_target_ready_q <= 1'b0;
      defer_q <= 1'b0;
      wrV_q <= 1'b0;
      rdData_q <= '0;
      wr_q <= '0;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      cmdA_q <= cmdA_d;
      cmdB_q <= cmdB_d;
      snoop_hit_modified_q <= snoop_hit_modified_d;
      lock_q <= lock_d;
      rsp_q <= rsp_d;
      bnr_q <= bnr_d;
      priority_agent_request_q <= priority_agent_request_d;
      data_valid_strobe_q <= data_valid_strobe_d;
      host_target_ready_q <= host_target_ready_d;
      defer_q <= defer_d;
      wrV_q <= wrV_d;
      rdData_q <= rdData_d;
      wr_q <= wr_d;
    end
  end

  // ----------------------------------------------------------------
  // pin drive: low level asserts, enable released when idle
  // ----------------------------------------------------------------
  assign blockNextRequestN = ~bnr_q;
  assign blockNextRequestOeN = ~bnr_q;
  assign priorityAgentRequestN = ~priority_agent_request_q;
  assign priorityAgentRequestOeN = ~priority_agent_request_q;
  // R7 every transfer here is a single clock, so busy stays released
  assign dataBusBusyN = 1'b1;
  assign dataBusBusyOeN = 1'b1;
  assign dataValidStrobeN = ~data_valid_strobe_q;
  assign dataValidStrobeOeN = ~data_valid_strobe_q;
  assign hostTargetReadyN = ~host_target_ready_q;
  assign hostTargetReadyOeN = ~host_target_ready_q;
  assign deferN = ~defer_q;
  assign deferOeN = ~defer_q;
  // R14 rsp_q only ever holds the six legal codes of the type
  assign responseStatusN = ~rsp_q;
  assign responseStatusOeN = (rsp_q == RSP_IDLE);
  // R15 read data leaves inverted; R18 no ECC lanes exist at all
  assign hostDataBusN = ~rdData_q;
  assign hostDataBusOeN = ~data_valid_strobe_q;

  // ----------------------------------------------------------------
  // local side of the bridge
  // ----------------------------------------------------------------
  assign cpuReqValid = (st_q == ST_WAIT);
  assign cpuReqAddr = addr_q;
  assign cpuReqCmdFirst = cmdA_q;
  assign cpuReqCmdSecond = cmdB_q;
  assign cpuReqSnoopHit = snoop_hit_modified_q;
  assign wrDataValid = wrV_q;
  assign wrData = wr_q;
  // R11 io and graphics paths hold off snoopable accesses on this
  assign atomicHold = lock_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence sReqStart;
    strobeSeen;
  endsequence

  sequence sReqTwoClk;
    st_q == ST_REQ2 && bnr_q ##1 st_q == ST_WAIT && cpuReqValid;
  endsequence

  a_req_phase: assert property ( // R3
    sReqStart ##1 !processor_reset_out |-> sReqTwoClk or ##1 processor_reset_out)
    else $error("request phase not captured over two clocks");

  a_block_next: assert property ( // R6
    sReqStart |=> blockNextRequestN == 1'b0)
    else $error("no block while a request is in flight");

  a_rsp_legal: assert property ( // R14
    !responseStatusOeN |-> ~responseStatusN != 3'h3
      && ~responseStatusN != 3'h4)
    else $error("reserved or hard-failure response driven");

  a_defer_code: assert property ( // R8
    !deferN |-> ~responseStatusN inside {3'h1, 3'h2})
    else $error("defer asserted without retry or deferred code");

  a_data_strobe: assert property ( // R9
    ~responseStatusN == 3'h7 && !responseStatusOeN
      |-> !dataValidStrobeN && !hostDataBusOeN)
    else $error("normal response without data strobe");

  a_trdy_step: assert property ( // R12
    !hostTargetReadyN |=> hostTargetReadyN && st_q == ST_DATAIN)
    else $error("target ready not a single clock before data");

  a_data_invert: assert property ( // R15
    st_q == ST_DATAIN && !dataValidStrobeInN && !processor_reset_out
      |=> wrDataValid && wrData == ~$past(hostDataBusInN))
    else $error("write data not inverted from the bus");

  a_lock_end: assert property ( // R11
    hostLockInN |=> !atomicHold)
    else $error("atomic hold kept after lock negation");

  a_lock_start: assert property ( // R11
    sReqStart and !hostLockInN |=> atomicHold)
    else $error("locked request did not start atomic hold");

  a_reset_release: assert property ( // R19
    processor_reset_out |-> ##[1:2] (blockNextRequestOeN && dataValidStrobeOeN
      && hostTargetReadyOeN && deferOeN && responseStatusOeN))
    else $error("bus outputs not released after reset");

  a_prio_follow: assert property ( // R4
    busHoldReq && !processor_reset_out |=> !priorityAgentRequestN)
    else $error("priority request not raised");

endmodule

/* hdl/hbb_params.svh */
`ifndef HBB_PARAMS_SVH
`define HBB_PARAMS_SVH

// ----------------------------------------------------------------
// widths and positions of the host bus fields
// ----------------------------------------------------------------
`define HBB_ADDR_MSB 31
`define HBB_ADDR_LSB 3
`define HBB_CMD_W 5
`define HBB_DATA_W 64
`define HBB_RSP_W 3

// ----------------------------------------------------------------
// timing counts, in host clocks
// ----------------------------------------------------------------
// symmetric request zero stays asserted this long after cpu reset
`define HBB_SYMMETRIC_REQUEST_ZERO_TAIL 2'h2
// stages of the pin synchroniser
`define HBB_SYNC_STAGES 3

// ----------------------------------------------------------------
// reset values of the synchronised pin levels
// ----------------------------------------------------------------
// bit 0 io reset active, bit 1 suspend inactive, bit 2 not mobile
`define HBB_PIN_RESET 3'h1

`endif

/* hdl/hbb_pkg.sv */
package hbb_pkg;

  // response status codes as seen on the bus (active high view)
  typedef enum logic [2:0] {
    RSP_IDLE = 3'h0,
    RSP_RETRY = 3'h1,
    RSP_DEFERRED = 3'h2,
    RSP_NO_DATA = 3'h5,
    RSP_WRITEBACK = 3'h6,
    RSP_NORMAL = 3'h7
  } hbb_rsp_type;

  // answer that the memory and io paths give to a processor request
  typedef enum logic [2:0] {
    ANS_NORMAL,
    ANS_NO_DATA,
    ANS_RETRY,
    ANS_DEFER,
    ANS_WRITE
  } hbb_ans_type;

  // processor cycle sequencer
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ2,
    ST_WAIT,
    ST_TRDY,
    ST_DATAIN,
    ST_RESP
  } hbb_state_type;

endpackage

/* hdl/hbb_reset_gen.sv */
`timescale 1ns/1ns
`include "hbb_params.svh"
module hbb_reset_gen
  import hbb_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic ioBusResetInN,
  input wire logic suspendStatusInN,
  input wire logic mobileMode,
  hbb_rst_if.gen rst
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] rawIn;
  logic [2:0] level;
  localparam logic [2:0] PinReset = `HBB_PIN_RESET;

  assign rawIn = {mobileMode, ~suspendStatusInN, ~ioBusResetInN};

  // a level only moves once stages two and three agree
  for (genvar i = 0; i < 3; i++) begin : g_sync
    logic [`HBB_SYNC_STAGES-1:0] chain_q, chain_d;
    logic lvl_q, lvl_d;
    always_comb begin
      chain_d = {chain_q[1:0], rawIn[i]};
      lvl_d = (chain_q[1] == chain_q[2]) ? chain_q[2] : lvl_q;
    end
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        chain_q <= {`HBB_SYNC_STAGES{PinReset[i]}};
        lvl_q <= PinReset[i];
      end else begin
        chain_q <= chain_d;
        lvl_q <= lvl_d;
      end
    end
    assign level[i] = lvl_q;
  end

  // ----------------------------------------------------------------
  // processor reset and symmetric request zero
  // ----------------------------------------------------------------
  logic processor_reset_out_q, processor_reset_out_d, breq_q, breq_d;
  logic [1:0] tail_q, tail_d;

  // R1 reset sources: suspend only counts in mobile mode
  always_comb begin
    processor_reset_out_d = level[0] | (level[2] & level[1]);
    tail_d = processor_reset_out_q ? `HBB_SYMMETRIC_REQUEST_ZERO_TAIL :
      (tail_q != 2'h0 ? tail_q - 2'h1 : 2'h0);
    // R5 request held through reset, dropped two clocks later;
    // follows the next reset value so a fresh reset never outruns it
    breq_d = processor_reset_out_d | (tail_q > 2'h1);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      processor_reset_out_q <= 1'b1;
      breq_q <= 1'b1;
      tail_q <= `HBB_SYMMETRIC_REQUEST_ZERO_TAIL;
    end else begin
      processor_reset_out_q <= processor_reset_out_d;
      breq_q <= breq_d;
      tail_q <= tail_d;
    end
  end

  assign rst.cpuResetAct = processor_reset_out_q;
  assign rst.breq0Act = breq_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence sBreqTail;
    breq_q ##1 breq_q ##1 !breq_q;
  endsequence

  a_breq_tail: assert property ( // R5
    @(posedge clock) disable iff (!nrst) $fell(processor_reset_out_q) |-> sBreqTail)
    else $error("symmetric request zero tail is not two clocks");

  a_breq_in_reset: assert property ( // R5
    @(posedge clock) disable iff (!nrst) processor_reset_out_q |-> breq_q)
    else $error("symmetric request zero dropped during cpu reset");

endmodule

/* hdl/hbb_rst_if.sv */
`timescale 1ns/1ns
// reset state passed from the reset generator to the bus core
interface hbb_rst_if;
  logic cpuResetAct;
  logic breq0Act;
  modport gen(output cpuResetAct, output breq0Act);
  modport core(input cpuResetAct, input breq0Act);
endinterface

/* sim/hbb_cpu_model.sv */
`timescale 1ns/1ns
`include "hbb_params.svh"
// processor core on the far side of the host bus; it drives on the falling
// edge so that every rising edge of the bridge sees settled levels
module hbb_cpu_model (
  input wire logic clock,
  input wire logic blockNextRequestN,
  input wire logic hostTargetReadyN,
  output logic requestStrobeInN,
  output logic [`HBB_CMD_W-1:0] requestCommandInN,
  output logic [`HBB_ADDR_MSB:`HBB_ADDR_LSB] hostAddrInN,
  output logic hostLockInN,
  output logic snoopHitModifiedInN,
  output logic dataValidStrobeInN,
  output logic [`HBB_DATA_W-1:0] hostDataBusInN
);
  // released lines float to the termination level, all ones
  // all lines idle high
  initial begin
    requestStrobeInN = 1'b1;
    requestCommandInN = '1;
    hostAddrInN = '1;
    hostLockInN = 1'b1;
    snoopHitModifiedInN = 1'b1;
    dataValidStrobeInN = 1'b1;
    hostDataBusInN = '1;
  end

  // ------------------------------------------------------------
  // request phase
  // ------------------------------------------------------------
  task automatic issue(input logic [`HBB_ADDR_MSB:`HBB_ADDR_LSB] addr,
      input logic [4:0] cmd1, input logic [4:0] cmd2, input logic hit);
    int i;
    for (i = 0; i < 50 && blockNextRequestN !== 1'b1; i++) begin
      @(negedge clock);
    end
    // strobe only in the first clock
    @(negedge clock);
    requestStrobeInN = 1'b0;
    requestCommandInN = ~cmd1;
    hostAddrInN = ~addr;
    // rest of the type, snoop result
    @(negedge clock);
    requestStrobeInN = 1'b1;
    requestCommandInN = ~cmd2;
    snoopHitModifiedInN = ~hit;
    @(negedge clock);
    requestCommandInN = '1;
    hostAddrInN = '1;
    snoopHitModifiedInN = 1'b1;
  endtask

  task automatic set_lock(input logic on);
    @(negedge clock);
    hostLockInN = ~on;
  endtask

  // ------------------------------------------------------------
  // data phase; single beat, so data bus busy is never needed
  // ------------------------------------------------------------
  task automatic write_beat(input logic [`HBB_DATA_W-1:0] data);
    int i;
    // data only once the target is ready
    for (i = 0; i < 50 && hostTargetReadyN !== 1'b0; i++) begin
      @(negedge clock);
    end
    @(negedge clock);
    dataValidStrobeInN = 1'b0;
    hostDataBusInN = ~data;
    @(negedge clock);
    dataValidStrobeInN = 1'b1;
    hostDataBusInN = '1;
  endtask
endmodule

/* sim/hbb_host_bridge_tb.sv */
`timescale 1ns/1ns
`include "hbb_params.svh"
module hbb_host_bridge_tb
  import hbb_pkg::*;
();
  logic clock = 1'b0;
  logic nrst, ioBusResetInN, suspendStatusInN, mobileMode, busHoldReq;
  logic processorResetOutN, symmetricRequestZeroN, symmetricRequestZeroOeN;
  logic priorityAgentRequestN, priorityAgentRequestOeN, requestStrobeInN;
  logic [4:0] requestCommandInN, cpuReqCmdFirst, cpuReqCmdSecond;
  logic [31:3] hostAddrInN, cpuReqAddr;
  logic hostLockInN, snoopHitModifiedInN, blockNextRequestN;
  logic blockNextRequestOeN, dataBusBusyN, dataBusBusyOeN;
  logic dataValidStrobeInN, dataValidStrobeN, dataValidStrobeOeN;
  logic hostTargetReadyN, hostTargetReadyOeN, deferN, deferOeN;
  logic [2:0] responseStatusN;
  logic responseStatusOeN, hostDataBusOeN, cpuReqValid, cpuReqSnoopHit;
  logic [63:0] hostDataBusInN, hostDataBusN, ansData, wrData;
  logic ansValid, wrDataValid, atomicHold;
  hbb_ans_type ansKind;
  int badCount = 0;
  int nCompared = 0;
  int cycleCount = 0;

  always #25 clock = ~clock;

  hbb_host_bridge u_dut (.clock, .nrst, .ioBusResetInN, .suspendStatusInN,
    .mobileMode, .processorResetOutN, .symmetricRequestZeroN,
    .symmetricRequestZeroOeN, .priorityAgentRequestN,
    .priorityAgentRequestOeN, .requestStrobeInN, .requestCommandInN,
    .hostAddrInN, .hostLockInN, .snoopHitModifiedInN, .blockNextRequestN,
    .blockNextRequestOeN, .dataBusBusyN, .dataBusBusyOeN,
    .dataValidStrobeInN, .dataValidStrobeN, .dataValidStrobeOeN,
    .hostTargetReadyN, .hostTargetReadyOeN, .deferN, .deferOeN,
    .responseStatusN, .responseStatusOeN, .hostDataBusInN, .hostDataBusN,
    .hostDataBusOeN, .busHoldReq, .cpuReqValid, .cpuReqAddr,
    .cpuReqCmdFirst, .cpuReqCmdSecond, .cpuReqSnoopHit, .ansValid, .ansKind,
    .ansData, .wrDataValid, .wrData, .atomicHold);

  hbb_cpu_model u_cpu (.clock, .blockNextRequestN, .hostTargetReadyN,
    .requestStrobeInN, .requestCommandInN, .hostAddrInN, .hostLockInN,
    .snoopHitModifiedInN, .dataValidStrobeInN, .hostDataBusInN);

  // ------------------------------------------------------------
  // compares and closing
  // ------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [63:0] got, input logic [63:0] exp);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task closeOut;
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // a hang costs a mismatch; the whole run needs under a hundred clocks
  always @(posedge clock) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 3000) begin
      badCount++;
      closeOut;
    end
  end

  // every response driven must be one of the legal codes
  always @(negedge clock) begin
    if (responseStatusOeN === 1'b0) begin
      chk_bit(responseStatusN inside {3'h3, 3'h4}, 1'b0);
    end
  end

  // ------------------------------------------------------------
  // one processor transaction, answered with the given kind
  // ------------------------------------------------------------
  task automatic run_tx(input logic wr, input logic hit,
      input hbb_ans_type kind, input logic [63:0] d, input logic [2:0] rsp);
    int i;
    logic [4:0] c1;
    logic [4:0] c2;
    c1 = {4'h9, wr};
    c2 = {wr, 4'h6};
    u_cpu.issue(d[31:3], c1, c2, hit);
    for (i = 0; i < 10 && cpuReqValid !== 1'b1; i++) @(negedge clock);
    chk_bit(cpuReqValid, 1'b1);
    chk_bit(blockNextRequestN, 1'b0);
    chk_vec(64'(cpuReqAddr), 64'(d[31:3]));
    chk_vec(64'(cpuReqCmdFirst), 64'(c1));
    chk_vec(64'(cpuReqCmdSecond), 64'(c2));
    chk_bit(cpuReqSnoopHit, hit);
    ansValid = 1'b1;
    ansKind = kind;
    ansData = d;
    @(negedge clock);
    ansValid = 1'b0;
    // target ready pulses one clock for writes and modified hits
    chk_bit(hostTargetReadyN | hostTargetReadyOeN, !(wr | hit));
    if (wr) u_cpu.write_beat(d);
    for (i = 0; i < 10 && responseStatusOeN !== 1'b0; i++) @(negedge clock);
    chk_vec(64'(responseStatusN ^ 3'h7), 64'(rsp));
    chk_bit(deferN, !(kind == ANS_RETRY || kind == ANS_DEFER));
    chk_bit(deferOeN, !(kind == ANS_RETRY || kind == ANS_DEFER));
    chk_bit(dataValidStrobeN, kind != ANS_NORMAL);
    chk_bit(dataValidStrobeOeN, kind != ANS_NORMAL);
    chk_bit(hostDataBusOeN, kind != ANS_NORMAL);
    if (kind == ANS_NORMAL) begin
      chk_vec(~hostDataBusN, d);
    end
    if (wr) begin
      chk_bit(wrDataValid, 1'b1);
      chk_vec(wrData, d);
    end
    @(negedge clock);
    chk_bit(responseStatusOeN, 1'b1);
    @(negedge clock);
    chk_bit(blockNextRequestN, 1'b1);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    int i;
    chk_bit(processorResetOutN, 1'b0);
    chk_bit(symmetricRequestZeroOeN, 1'b0);
    chk_bit(symmetricRequestZeroN, 1'b0);
    chk_bit(dataBusBusyN, 1'b1);
    chk_bit(&{blockNextRequestOeN, hostTargetReadyOeN, deferOeN,
      responseStatusOeN, hostDataBusOeN, dataValidStrobeOeN,
      dataBusBusyOeN, priorityAgentRequestOeN}, 1'b1);
    ioBusResetInN = 1'b1;
    for (i = 0; i < 20 && processorResetOutN !== 1'b1; i++) @(negedge clock);
    chk_bit(processorResetOutN, 1'b1);
    chk_bit(symmetricRequestZeroOeN, 1'b0);
    @(negedge clock);
    chk_bit(symmetricRequestZeroOeN, 1'b0);
    @(negedge clock);
    chk_bit(symmetricRequestZeroOeN, 1'b1);
  endtask

  task automatic t_data;
    run_tx(1'b0, 1'b0, ANS_NORMAL, 64'hA5C3_0F1E_7788_9900, 3'h7);
    run_tx(1'b1, 1'b0, ANS_WRITE, 64'h0123_4567_89AB_CDEF, 3'h5);
    run_tx(1'b1, 1'b1, ANS_WRITE, 64'hFEDC_BA98_7654_3218, 3'h6);
  endtask

  task automatic t_codes;
    hbb_ans_type k[3] = '{ANS_RETRY, ANS_DEFER, ANS_NO_DATA};
    logic [2:0] r[3] = '{3'h1, 3'h2, 3'h5};
    for (int j = 0; j < 3; j++) begin
      run_tx(1'b0, 1'b0, k[j], 64'h0000_0000_0000_0048 << j, r[j]);
    end
  endtask

  task automatic t_lock;
    u_cpu.set_lock(1'b1);
    run_tx(1'b0, 1'b0, ANS_NO_DATA, 64'h0000_0000_0000_1230, 3'h5);
    chk_bit(atomicHold, 1'b1);
    u_cpu.set_lock(1'b0);
    repeat (2) @(negedge clock);
    chk_bit(atomicHold, 1'b0);
  endtask

  task automatic t_prio;
    busHoldReq = 1'b1;
    @(negedge clock);
    chk_bit(priorityAgentRequestN | priorityAgentRequestOeN, 1'b0);
    busHoldReq = 1'b0;
    @(negedge clock);
    chk_bit(priorityAgentRequestOeN, 1'b1);
  endtask

  task automatic t_mobile;
    int i;
    // suspend alone must not reset the processor outside mobile mode
    suspendStatusInN = 1'b0;
    repeat (8) @(negedge clock);
    chk_bit(processorResetOutN, 1'b1);
    mobileMode = 1'b1;
    for (i = 0; i < 20 && processorResetOutN !== 1'b0; i++) @(negedge clock);
    chk_bit(processorResetOutN, 1'b0);
    repeat (2) @(negedge clock);
    chk_bit(blockNextRequestOeN & responseStatusOeN, 1'b1);
    chk_bit(symmetricRequestZeroOeN, 1'b0);
  endtask

  initial begin
    nrst = 1'b0;
    ioBusResetInN = 1'b0;
    suspendStatusInN = 1'b1;
    mobileMode = 1'b0;
    busHoldReq = 1'b0;
    ansValid = 1'b0;
    ansKind = ANS_NORMAL;
    ansData = '0;
    repeat (3) @(negedge clock);
    nrst = 1'b1;
    t_reset;
    t_data;
    t_codes;
    t_lock;
    t_prio;
    t_mobile;
    closeOut;
  end
endmodule
